//--- rtl/udma_out_ctrl.sv
// Purpose: device end of a host-to-device ultra dma burst: pause, both terminations, crc check
// Assumes: all link pins asynchronous to clk, two-flop synchronised; link period well above 4 clocks
// Notes: data and strobe share the same synchroniser depth so a word lines up with its edge
// Functional notes
// - no pause before first word of burst
// - pause: ready negated, request held high
// - resume by asserting ready again
// - accept up to three words after negation
// - buffer absorbs three words after ready negation
// - no termination before first word; negate ready
// - drop request tRP after ready; keep low
// - strobe raise after request drop ignored
// - capture host crc on ack negation
// - compare crc, keep first error per command
// - host stop: drop request within tLI
// - host stop: negate ready, keep negated
// - release ready within tIORDYZ of ack negation
// - outside burst, link lines mean nothing here
// - crc seeded 4ABA at burst start
// - crc x16+x12+x5+1, bit 0 first
// - crc error sets icrc and abort bits
`timescale 1ns/1ps
module udma_out_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  // link pins
  input wire logic dmack_n,
  input wire logic stop,
  input wire logic hstrobe,
  input wire logic [udma_pkg::DATA_W-1:0] data_in,
  output logic dmarq,
  output logic ddmardy_n,
  output logic ddmardy_oe_n,
  // user side
  input wire logic cmd_start,
  input wire logic cmd_end,
  input wire logic burst_req,
  input wire logic pause_req,
  input wire logic term_req,
  output logic word_valid,
  input wire logic word_ready,
  output logic [udma_pkg::DATA_W-1:0] word_data,
  output logic burst_done,
  output logic crc_error,
  output logic [7:0] err_reg
);
  import udma_pkg::*;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [1:0] dmack_n_q;
  logic [1:0] stop_q;
  logic [1:0] hs_q;
  logic [DATA_W-1:0] din_q1;
  logic [DATA_W-1:0] din_q2;
  logic hs_d_q;
  logic dmack_d_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dmack_n_q <= 2'h3;
      stop_q <= 2'h0;
      hs_q <= 2'h3;
      din_q1 <= '0;
      din_q2 <= '0;
      hs_d_q <= 1'b1;
      dmack_d_q <= 1'b1;
    end else begin
      dmack_n_q <= {dmack_n_q[0], dmack_n};
      stop_q <= {stop_q[0], stop};
      hs_q <= {hs_q[0], hstrobe};
      din_q1 <= data_in;
      din_q2 <= din_q1;
      hs_d_q <= hs_q[1];
      dmack_d_q <= dmack_n_q[1];
    end
  end

  logic ack_s;
  logic stop_s;
  logic hs_edge;
  logic ack_rise;
  assign ack_s = !dmack_n_q[1];
  assign stop_s = stop_q[1];
  assign hs_edge = hs_q[1] ^ hs_d_q;
  assign ack_rise = dmack_n_q[1] && !dmack_d_q;

  // ****************************************
  // state and link outputs
  // ****************************************
  state_t state_q;
  state_t state_d;
  logic dmarq_q;
  logic rdy_n_q;
  logic rdy_oe_n_q;
  logic words_q;
  logic [RP_CNT_W-1:0] rp_q;
  logic [FIFO_AW:0] fcount;
  logic room_low;
  logic want_pause;
  logic take_word;
  logic fifo_ready;

  // pausing on room keeps the three words in flight from overflowing
  assign room_low = (fcount >= (FIFO_AW + 1)'(FIFO_DEPTH - PAUSE_FREE));
  assign want_pause = pause_req || room_low;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (burst_req) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        if (ack_s && !stop_s) begin
          state_d = ST_XFER;
        end
      end
      ST_XFER: begin
        if (stop_s && words_q) begin
          state_d = ST_TERM;
        end else if (term_req && words_q) begin
          state_d = ST_TWAIT;
        end else if (want_pause && words_q) begin
          state_d = ST_PAUSE;
        end
      end
      ST_PAUSE: begin
        if (stop_s) begin
          state_d = ST_TERM;
        end else if (term_req) begin
          state_d = ST_TWAIT;
        end else if (!want_pause) begin
          state_d = ST_XFER;
        end
      end
      ST_TWAIT: begin
        if (stop_s || rp_q >= RP_CNT_W'(RP_CYC)) begin
          state_d = ST_TERM;
        end
      end
      ST_TERM: begin
        if (ack_rise) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request stays high through a pause, low only to end the burst
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dmarq_q <= 1'b0;
    end else begin
      dmarq_q <= (state_d == ST_REQ) || (state_d == ST_XFER) || (state_d == ST_PAUSE) ||
                 (state_d == ST_TWAIT);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_n_q <= 1'b1;
    end else begin
      rdy_n_q <= (state_d != ST_XFER);
    end
  end

  // drive ready only while ack is held; let go on ack release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdy_oe_n_q <= 1'b1;
    end else if (ack_rise || state_d == ST_IDLE) begin
      rdy_oe_n_q <= 1'b1;
    end else if (ack_s && state_q != ST_IDLE) begin
      rdy_oe_n_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rp_q <= '0;
    end else if (state_q != ST_TWAIT) begin
      rp_q <= '0;
    end else if (rp_q != '1) begin
      rp_q <= rp_q + 1'b1;
    end
  end

  // ****************************************
  // word capture and crc
  // ****************************************
  // edges only count while request is high; the closing raise is not data
  assign take_word = hs_edge && ack_s && dmarq_q &&
                     (state_q == ST_XFER || state_q == ST_PAUSE || state_q == ST_TWAIT);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      words_q <= 1'b0;
    end else if (state_q == ST_REQ) begin
      words_q <= 1'b0;
    end else if (take_word) begin
      words_q <= 1'b1;
    end
  end

  logic [15:0] crc_q;
  logic [15:0] crc_next;

  udma_crc16 u_crc (
    .crc_in(crc_q),
    .data(din_q2),
    .crc_out(crc_next)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_q <= CRC_SEED;
    end else if (state_q == ST_IDLE && state_d == ST_REQ) begin
      crc_q <= CRC_SEED;
    end else if (take_word) begin
      crc_q <= crc_next;
    end
  end

  // extra words past the command end are still pushed; the consumer discards them
  udma_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(take_word),
    .in_ready(fifo_ready),
    .in_data(din_q2),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data),
    .count(fcount)
  );

  // ****************************************
  // crc compare and error report
  // ****************************************
  logic mismatch;
  logic err_q;
  logic done_q;
  logic [7:0] err_reg_q;
  logic [15:0] host_crc_q;

  assign mismatch = (state_q == ST_TERM) && ack_rise && (din_q2 != crc_q);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      host_crc_q <= '0;
    end else if (state_q == ST_TERM && ack_rise) begin
      host_crc_q <= din_q2;
    end
  end

  // set beats clear; later clean bursts never wipe a held error
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_q <= 1'b0;
    end else if (mismatch) begin
      err_q <= 1'b1;
    end else if (cmd_start) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      err_reg_q <= ERR_RESET;
    end else if (cmd_end) begin
      err_reg_q <= ERR_RESET;
      err_reg_q[ERR_ICRC_BIT] <= err_q || mismatch;
      err_reg_q[ERR_ABRT_BIT] <= err_q || mismatch;
    end else if (cmd_start) begin
      err_reg_q <= ERR_RESET;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == ST_TERM) && ack_rise;
    end
  end

  assign dmarq = dmarq_q;
  assign ddmardy_n = rdy_n_q;
  assign ddmardy_oe_n = rdy_oe_n_q;
  assign burst_done = done_q;
  assign crc_error = err_q;
  assign err_reg = err_reg_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  int rp_seen;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rp_seen <= 0;
    end else if (!rdy_n_q) begin
      rp_seen <= 0;
    end else if (rp_seen < 1000) begin
      rp_seen <= rp_seen + 1;
    end
  end

  pause_first_word_a: assert property (
    (state_q == ST_XFER && state_d == ST_PAUSE) |-> words_q)
    else $error("pause before any word");
  pause_keeps_req_a: assert property (
    (state_q == ST_PAUSE) |-> dmarq_q && rdy_n_q)
    else $error("pause lost request or ready");
  resume_ready_a: assert property (
    (state_q == ST_PAUSE && state_d == ST_XFER) |=> !rdy_n_q)
    else $error("resume did not assert ready");
  term_first_word_a: assert property (
    (state_q == ST_XFER && state_d == ST_TWAIT) |-> words_q)
    else $error("termination before any word");
  req_drop_delay_a: assert property (
    ($fell(dmarq_q) && !$past(stop_s)) |-> rdy_n_q && rp_seen >= RP_CYC)
    else $error("request dropped too soon after ready");
  closing_edge_a: assert property (
    !dmarq_q |-> !take_word)
    else $error("edge taken with request low");
  host_stop_drop_a: assert property (
    (stop_s && (state_q == ST_XFER || state_q == ST_PAUSE) && words_q) |=> !dmarq_q ##1 !dmarq_q)
    else $error("request not dropped on host stop");
  host_stop_rdy_a: assert property (
    (state_q == ST_TERM) |-> rdy_n_q)
    else $error("ready asserted during termination");
  rdy_release_a: assert property (
    ack_rise |-> ##[1:2] rdy_oe_n_q)
    else $error("ready not released after ack");
  crc_seed_a: assert property (
    (state_q == ST_REQ) |-> crc_q == CRC_SEED)
    else $error("crc not seeded");
  first_err_a: assert property (
    (err_q && !cmd_start) |=> err_q)
    else $error("held crc error lost");
  err_bits_a: assert property (
    (cmd_end && err_q) |=> err_reg_q[ERR_ICRC_BIT] && err_reg_q[ERR_ABRT_BIT])
    else $error("error bits not reported");
  no_overflow_a: assert property (
    take_word |-> fifo_ready)
    else $error("word lost to full buffer");

  pause_cov_c: cover property (state_q == ST_PAUSE ##1 state_q == ST_XFER);
  dev_term_c: cover property (state_q == ST_TWAIT ##1 state_q == ST_TERM);
  host_term_c: cover property (state_q == ST_XFER ##1 state_q == ST_TERM);
  crc_bad_c: cover property (mismatch);
endmodule

//--- rtl/udma_pkg.sv
// Purpose: shared constants and types for the write-burst receive block
// Assumes: 125 MHz core clock; link timings given in ns
// Notes: timing figures that the block needs but nobody supplies are plain defaults
package udma_pkg;

  // ****************************************
  // widths and sizes
  // ****************************************
  localparam int DATA_W = 16;
  localparam int FIFO_DEPTH = 8;
  localparam int FIFO_AW = 3;
  // pause once free slots drop to this: three in flight plus the synchroniser word
  localparam int PAUSE_FREE = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS = 8000;
  localparam int T_RP_NS = 160;
  localparam int T_LI_NS = 150;
  localparam int T_IORDYZ_NS = 20;
  // least time: round up
  localparam int RP_CYC = (T_RP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // longest times: round down, never below one
  localparam int LI_CYC = (T_LI_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 : (T_LI_NS * 1000 / CLK_PERIOD_PS);
  localparam int IORDYZ_CYC = (T_IORDYZ_NS * 1000 / CLK_PERIOD_PS) < 1 ? 1 : (T_IORDYZ_NS * 1000 / CLK_PERIOD_PS);
  localparam int RP_CNT_W = 8;

  // ****************************************
  // crc and error report
  // ****************************************
  localparam logic [15:0] CRC_SEED = 16'h4ABA;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam int ERR_ICRC_BIT = 7;
  localparam int ERR_ABRT_BIT = 2;
  localparam logic [7:0] ERR_RESET = 8'h00;

  // ****************************************
  // burst states
  // ****************************************
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_REQ = 6'h02,
    ST_XFER = 6'h04,
    ST_PAUSE = 6'h08,
    ST_TWAIT = 6'h10,
    ST_TERM = 6'h20
  } state_t;

endpackage

//--- rtl/udma_fifo.sv
// Purpose: small synchronous FIFO for received words
// Assumes: single clock, valid/ready on both sides
// Notes: push when full is refused via in_ready
`timescale 1ns/1ps
module udma_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [AW:0] count
);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q < (AW + 1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

//--- rtl/udma_crc16.sv
// Purpose: one-word step of the 16-bit interface crc
// Assumes: combinational; caller holds the running value
// Notes: equals sixteen serial shifts, bit 0 first
`timescale 1ns/1ps
module udma_crc16 (
  input wire logic [15:0] crc_in,
  input wire logic [15:0] data,
  output logic [15:0] crc_out
);
  import udma_pkg::*;

  always_comb begin
    logic [15:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = 0; i < 16; i++) begin
      fb = c[15] ^ data[i];
      c = {c[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
    end
    crc_out = c;
  end
endmodule

//--- verif/udma_host_model.sv
// Purpose: behavioural host end of a write burst
// Assumes: device ready line pulled up when released; strobe period 125 ns
// Notes: waits are bounded; ok reports a wait that ran out
`timescale 1ns/1ps
module udma_host_model (
  output logic dmack_n,
  output logic stop,
  output logic hstrobe,
  output logic [15:0] data_in,
  input wire logic dmarq,
  input wire logic rdy_n
);
  logic [15:0] crc_q;
  int late;
  initial begin
    dmack_n = 1'b1;
    stop = 1'b0;
    hstrobe = 1'b1;
    data_in = 16'h0000;
    crc_q = 16'h4ABA;
    late = 0;
  end
  // ****************************************
  // link sequences
  // ****************************************
  task automatic wait_for(input bit on_rdy, input logic lvl, output bit ok);
    int n;
    n = 0;
    while ((on_rdy ? rdy_n : dmarq) !== lvl && n < 3000) begin
      #5;
      n++;
    end
    ok = (n < 3000);
  endtask
  task automatic open_burst(output bit ok);
    wait_for(1'b0, 1'b1, ok);
    if (!ok) return;
    stop = 1'b1;
    hstrobe = 1'b1;
    crc_q = 16'h4ABA;
    #40 dmack_n = 1'b0;
    #40 stop = 1'b0;
    wait_for(1'b1, 1'b0, ok);
  endtask
  task automatic send(input int n, input logic [15:0] base, output bit ok);
    int left;
    logic fb;
    logic [15:0] w;
    left = late;
    ok = 1'b1;
    for (int i = 0; i < n; i++) begin
      // cable delay: a few words may still go out after ready drops
      if (rdy_n !== 1'b0) begin
        if (left > 0) begin
          left--;
        end else begin
          wait_for(1'b1, 1'b0, ok);
          if (!ok) return;
          left = late;
        end
      end
      w = base + 16'(i);
      data_in = w;
      for (int b = 0; b < 16; b++) begin
        fb = crc_q[15] ^ w[b];
        crc_q = {crc_q[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
      end
      #31 hstrobe = ~hstrobe;
      #31.5;
    end
  endtask
  task automatic finish(input bit host_term, input bit bad, output bit ok);
    if (host_term) begin
      #40 stop = 1'b1;
      wait_for(1'b0, 1'b0, ok);
    end else begin
      wait_for(1'b0, 1'b0, ok);
      #20 stop = 1'b1;
    end
    if (!ok) return;
    #20 hstrobe = 1'b1;
    data_in = bad ? ~crc_q : crc_q;
    #100 dmack_n = 1'b1;
    #40 stop = 1'b0;
    data_in = ~data_in;
  endtask
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for the write-burst device end
// Assumes: 125 MHz clock, host model on the link side
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb;
  import udma_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, cmd_start = 1'b0, cmd_end = 1'b0, burst_req = 1'b0;
  logic pause_req = 1'b0, term_req = 1'b0, word_ready = 1'b0;
  logic dmack_n, stop, hstrobe, dmarq, ddmardy_n, ddmardy_oe_n, rdy_line, word_valid, burst_done, crc_error;
  logic [15:0] data_in, word_data;
  logic [7:0] err_reg;
  int errors = 0, cmp_count = 0, n;
  bit ok;
  always #4 clk = ~clk;
  // released ready line floats to its pull-up
  assign rdy_line = ddmardy_oe_n ? 1'b1 : ddmardy_n;
  udma_out_ctrl udma_out_ctrl_i (.clk(clk), .reset_n(reset_n), .dmack_n(dmack_n), .stop(stop),
    .hstrobe(hstrobe), .data_in(data_in), .dmarq(dmarq), .ddmardy_n(ddmardy_n),
    .ddmardy_oe_n(ddmardy_oe_n), .cmd_start(cmd_start), .cmd_end(cmd_end), .burst_req(burst_req),
    .pause_req(pause_req), .term_req(term_req), .word_valid(word_valid), .word_ready(word_ready),
    .word_data(word_data), .burst_done(burst_done), .crc_error(crc_error), .err_reg(err_reg));
  udma_host_model udma_host_model_i (.dmack_n(dmack_n), .stop(stop), .hstrobe(hstrobe),
    .data_in(data_in), .dmarq(dmarq), .rdy_n(rdy_line));
  // ****************************************
  // helpers
  // ****************************************
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic okc();
    if (!ok) begin
      errors++;
      $display("BAD %0t host wait ran out", $time);
      wrap_up();
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return word_valid;
      1: return ddmardy_n;
      2: return burst_done;
      default: return stop;
    endcase
  endfunction
  task automatic wait_out(input int w, input logic lvl);
    int k;
    k = 0;
    while (pick(w) !== lvl && k < 3000) begin
      tick();
      k++;
    end
    if (k == 3000) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      wrap_up();
    end
  endtask
  task automatic drain(input int cnt, input logic [15:0] base);
    for (int i = 0; i < cnt; i++) begin
      wait_out(0, 1'b1);
      check(word_data, base + 16'(i), "word");
      word_ready = 1'b1;
      tick();
      word_ready = 1'b0;
      tick();
    end
  endtask
  task automatic open();
    burst_req = 1'b1;
    tick();
    burst_req = 1'b0;
    udma_host_model_i.open_burst(ok);
    okc();
  endtask
  task automatic close(input bit host_term, input bit bad);
    fork
      udma_host_model_i.finish(host_term, bad, ok);
      begin
        n = 0;
        if (host_term) begin
          wait_out(3, 1'b1);
          while (dmarq === 1'b1 && n < 100) begin tick(); n++; end
          check(16'(n <= LI_CYC), 16'h0001, "late request drop");
        end else begin
          wait_out(1, 1'b1);
          while (dmarq === 1'b1 && n < 100) begin tick(); n++; end
          check(16'(n >= RP_CYC), 16'h0001, "early request drop");
        end
        check({15'h0000, ddmardy_n}, 16'h0001, "ready during end");
        wait_out(2, 1'b1);
        check({15'h0000, ddmardy_oe_n}, 16'h0001, "ready not released");
      end
    join
    okc();
    repeat (3) tick();
    check({14'h0000, dmarq, word_valid}, 16'h0000, "request or extra word");
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic sc_host_term();
    cmd_start = 1'b1;
    tick();
    cmd_start = 1'b0;
    open();
    pause_req = 1'b1;
    repeat (10) tick();
    check({15'h0000, ddmardy_n}, 16'h0000, "pause before data");
    pause_req = 1'b0;
    fork
      udma_host_model_i.send(6, 16'h1000, ok);
      begin
        wait_out(0, 1'b1);
        pause_req = 1'b1;
        wait_out(1, 1'b1);
        check({15'h0000, dmarq}, 16'h0001, "request during pause");
        repeat (30) tick();
        pause_req = 1'b0;
        drain(6, 16'h1000);
      end
    join
    okc();
    close(1'b1, 1'b0);
    check({15'h0000, crc_error}, 16'h0000, "good crc flagged");
  endtask
  task automatic sc_dev_term();
    open();
    // drain alongside: five words would otherwise trip the room pause and stall the host
    fork
      udma_host_model_i.send(5, 16'h2000, ok);
      drain(5, 16'h2000);
    join
    okc();
    term_req = 1'b1;
    close(1'b0, 1'b1);
    term_req = 1'b0;
    check({15'h0000, crc_error}, 16'h0001, "bad crc missed");
    open();
    udma_host_model_i.send(3, 16'h3000, ok);
    okc();
    drain(3, 16'h3000);
    close(1'b1, 1'b0);
    check({15'h0000, crc_error}, 16'h0001, "first error lost");
    cmd_end = 1'b1;
    tick();
    cmd_end = 1'b0;
    tick();
    check({8'h00, err_reg}, 16'h0084, "error register");
    cmd_start = 1'b1;
    tick();
    cmd_start = 1'b0;
    tick();
    check({err_reg, 7'h00, crc_error}, 16'h0000, "error not cleared");
  endtask
  task automatic sc_stall();
    open();
    udma_host_model_i.late = 2;
    fork
      udma_host_model_i.send(8, 16'h4000, ok);
      begin
        wait_out(1, 1'b1);
        check({15'h0000, dmarq}, 16'h0001, "request dropped on pause");
        repeat (40) tick();
        check({15'h0000, ddmardy_n}, 16'h0001, "ready while full");
        drain(8, 16'h4000);
      end
    join
    okc();
    udma_host_model_i.late = 0;
    close(1'b1, 1'b0);
    check({15'h0000, crc_error}, 16'h0000, "late words broke crc");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    check({10'h000, dmarq, ddmardy_n, ddmardy_oe_n, word_valid, burst_done, crc_error}, 16'h0018, "reset");
    check({8'h00, err_reg}, 16'h0000, "reset error register");
    @(posedge clk);
    #1 reset_n = 1'b1;
    sc_host_term();
    sc_dev_term();
    sc_stall();
    wrap_up();
  end
endmodule
